// ### include/serial_engine_defs.vh
// Register map, field positions and timing constants of the serial shift engine.
`ifndef SERIAL_ENGINE_DEFS_VH
`define SERIAL_ENGINE_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define REG_CTRL       4'h0
`define REG_BUF        4'h4
`define REG_CFG        4'h8
`define REG_STAT       4'hc

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTRL_RX_DONE   0
`define CTRL_TX_DONE   1
`define CTRL_RX_NINTH  2
`define CTRL_TX_NINTH  3
`define CTRL_RX_EN     4
`define CTRL_FILTER    5
`define CTRL_MODE_LO   6
`define CTRL_MODE_HI   7

// Configuration register fields.
`define CFG_DOUBLE     0
`define CFG_TIMER2     1

// Status register fields.
`define STAT_SEND      0
`define STAT_RECV      1

// ----------------------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------------------
`define MODE_SHIFT     2'h0
`define MODE_8BIT      2'h1
`define MODE_9BIT_FIX  2'h2
`define MODE_9BIT_VAR  2'h3

// ----------------------------------------------------------------------------
// Timing: machine cycle of 12 oscillator clocks, 16 states per bit time
// ----------------------------------------------------------------------------
`define MC_LAST        4'hb
`define MC_CLK_LOW     4'h6
`define MC_SAMPLE      4'ha
`define OV_LAST        4'hf
`define VOTE_FIRST     4'h7
`define M2_DIV_SLOW    2'h3
`define M2_DIV_FAST    2'h1

// ----------------------------------------------------------------------------
// Shift register presets and markers
// ----------------------------------------------------------------------------
`define TX_MARK        8'h01
`define RX0_PRESET     8'hfe
`define RX_PRESET      9'h1ff

`endif

// ### hdl/majority_sampler.v
// Three-point bit detector: samples at counter states 7, 8 and 9 and votes.
`timescale 1ns/1ps
`include "serial_engine_defs.vh"

module majority_sampler (
   input  wire       mclk_in,
   input  wire       rstn_in,
   input  wire       tick_in,
   input  wire [3:0] count_in,
   input  wire       bit_in,
   output reg        vote_out
);

   reg [2:0] sample;

   // ----------------------------------------------------------------------------
   // Sample capture
   // ----------------------------------------------------------------------------
   // One capture flop per sample point; point i sits at state 7 + i.
   genvar i;
   generate
      for (i = 0; i < 3; i = i + 1) begin : g_point
         always @(posedge mclk_in or negedge rstn_in) begin
            if (!rstn_in)
               sample[i] <= 1'b1;
            else if (tick_in && (count_in == `VOTE_FIRST + i[3:0]))
               sample[i] <= bit_in;
         end
      end
   endgenerate

   // ----------------------------------------------------------------------------
   // Vote
   // ----------------------------------------------------------------------------
   // The vote settles one clock after the last sample, well before the rollover.
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in)
         vote_out <= 1'b1;
      else
         vote_out <= (sample[0] & sample[1]) | (sample[0] & sample[2]) |
                     (sample[1] & sample[2]);
   end

endmodule

// ### hdl/serial_port_shift_engine.v
// Serial port transmit and receive shift engines with an Avalon-MM register slave.
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "serial_engine_defs.vh"
// Operation
// - Mode 0 write loads marker, shifting next cycle.
// - Mode 0 send drives data and clock.
// - Mode 0 marker detect, last shift, set done.
// - Mode 0 receive start presets 11111110 register.
// - Mode 0 receive clocks, shifts in sampled bit.
// - Mode 0 zero reaches left, load buffer, flag.
// - Mode 1 send starts after counter rollover.
// - Start bit, then data, then shifting.
// - Mode 1 transmit done at tenth rollover.
// - Modes 2/3 load ninth bit, insert stop.
// - Modes 2/3 transmit done at eleventh rollover.
// - Falling edge resets counter, presets ones.
// - Majority of samples at states 7-9.
// - Nonzero start bit restarts edge hunting.
// - Mode 1 accepts frame only if conditions hold.
// - Modes 2/3 test the received ninth bit.
// - Return to hunting; modes 2/3 wait one bit.
// - Mode 2 fixed rate, mode 3 timer rate.
// - Mode 0 clock is oscillator over twelve.
// - Rate-double bit picks mode 2 divider.
// - Timer 1 rate halved unless doubled.

module serial_port_shift_engine (
   input  wire        mclk_in,
   input  wire        rstn_in,
   input  wire [3:0]  address_in,
   input  wire        read_in,
   input  wire        write_in,
   input  wire [31:0] writedata_in,
   input  wire [3:0]  byteenable_in,
   output reg  [31:0] readdata_out,
   output reg         waitrequest_out,
   input  wire        timer1_ovf_in,
   input  wire        timer2_ovf_in,
   input  wire        rxd_in,
   output reg         rxd_out,
   output reg         rxd_oe_out,
   output reg         txd_out
);

   // Mode 0 receive sequencer states.
   localparam [1:0] RX0_IDLE = 2'b00;
   localparam [1:0] RX0_WAIT = 2'b01;
   localparam [1:0] RX0_LOAD = 2'b10;
   localparam [1:0] RX0_RUN  = 2'b11;

   reg  [1:0]  mode;
   reg         rx_enable;
   reg         address_filter_bit;
   reg         tx_ninth_bit;
   reg         rate_double_bit;
   reg         use_timer2;
   reg         tx_done_flag;
   reg         rx_done_flag;
   reg         rx_ninth_bit;
   reg  [7:0]  serial_buffer;
   reg  [31:0] next_rdata;

   reg  [3:0]  mc_cnt;
   reg         t1_half;
   reg  [1:0]  m2_div;
   reg         tick;
   reg         next_tick;
   reg  [3:0]  tx_cnt;

   reg  [8:0]  tx_sr;
   reg         tx_pend;
   reg         tx_arm;
   reg         send;
   reg         tx_data_on;
   reg         tx_first;
   reg         ti_set;

   reg         rxd_meta;
   reg         rxd_sync;
   reg         rxd_prev;
   reg  [8:0]  rx_sr;
   reg  [3:0]  rx_cnt;
   reg         rx_busy;
   reg         rx_first;
   reg         rx_tail;
   reg  [1:0]  rx0_state;
   reg         receive;
   reg         rx0_sample;
   reg         ri_set;
   wire        vote;

   wire req      = read_in | write_in;
   wire take     = req & ~waitrequest_out;
   wire wr_ok    = take & write_in & byteenable_in[0];
   wire wr_ctrl  = wr_ok & (address_in == `REG_CTRL);
   wire wr_buf   = wr_ok & (address_in == `REG_BUF);
   wire wr_cfg   = wr_ok & (address_in == `REG_CFG);
   wire mode0    = (mode == `MODE_SHIFT);
   wire mc_end   = (mc_cnt == `MC_LAST);
   wire tx_roll  = tick & (tx_cnt == `OV_LAST);
   wire rx_roll  = tick & (rx_cnt == `OV_LAST);
   wire fall     = rxd_prev & ~rxd_sync;
   wire tx_last  = (tx_sr[8:1] == `TX_MARK);

   // ----------------------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------------------
   // Read data mux; unmapped addresses read as zero.
   always @* begin
      next_rdata = 32'h0;
      if (address_in == `REG_CTRL) begin
         next_rdata[`CTRL_MODE_HI:`CTRL_MODE_LO] = mode;
         next_rdata[`CTRL_FILTER]   = address_filter_bit;
         next_rdata[`CTRL_RX_EN]    = rx_enable;
         next_rdata[`CTRL_TX_NINTH] = tx_ninth_bit;
         next_rdata[`CTRL_RX_NINTH] = rx_ninth_bit;
         next_rdata[`CTRL_TX_DONE]  = tx_done_flag;
         next_rdata[`CTRL_RX_DONE]  = rx_done_flag;
      end else if (address_in == `REG_BUF) begin
         next_rdata[7:0] = serial_buffer;
      end else if (address_in == `REG_CFG) begin
         next_rdata[`CFG_DOUBLE] = rate_double_bit;
         next_rdata[`CFG_TIMER2] = use_timer2;
      end else if (address_in == `REG_STAT) begin
         next_rdata[`STAT_SEND] = send;
         next_rdata[`STAT_RECV] = rx_busy | receive;
      end
   end

   // Every access waits exactly one cycle, so read data can come from a flop.
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         waitrequest_out <= 1'b1;
         readdata_out    <= 32'h0;
      end else begin
         waitrequest_out <= ~(req & waitrequest_out);
         if (req & waitrequest_out & read_in)
            readdata_out <= next_rdata;
      end
   end

   // Control and configuration; a hardware set beats a software clear.
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mode               <= `MODE_SHIFT;
         rx_enable          <= 1'b0;
         address_filter_bit <= 1'b0;
         tx_ninth_bit       <= 1'b0;
         rate_double_bit    <= 1'b0;
         use_timer2         <= 1'b0;
         tx_done_flag       <= 1'b0;
         rx_done_flag       <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            mode               <= writedata_in[`CTRL_MODE_HI:`CTRL_MODE_LO];
            address_filter_bit <= writedata_in[`CTRL_FILTER];
            rx_enable          <= writedata_in[`CTRL_RX_EN];
            tx_ninth_bit       <= writedata_in[`CTRL_TX_NINTH];
         end
         if (wr_cfg) begin
            rate_double_bit <= writedata_in[`CFG_DOUBLE];
            use_timer2      <= writedata_in[`CFG_TIMER2];
         end
         tx_done_flag <= ti_set | (wr_ctrl ? writedata_in[`CTRL_TX_DONE] : tx_done_flag);
         rx_done_flag <= ri_set | (wr_ctrl ? writedata_in[`CTRL_RX_DONE] : rx_done_flag);
      end
   end

   // ----------------------------------------------------------------------------
   // Timebase
   // ----------------------------------------------------------------------------
   // Machine cycle of twelve oscillator clocks; mode 0 shifts once per cycle.
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in)
         mc_cnt <= 4'h0;
      else if (mc_end)
         mc_cnt <= 4'h0;
      else
         mc_cnt <= mc_cnt + 4'h1;
   end

   // Oversampling tick at sixteen times the bit rate.
   always @* begin
      if (mode == `MODE_9BIT_FIX)
         next_tick = (m2_div == (rate_double_bit ? `M2_DIV_FAST : `M2_DIV_SLOW));
      else if (use_timer2)
         next_tick = timer2_ovf_in;
      else
         next_tick = timer1_ovf_in & (rate_double_bit | t1_half);
   end

   // The timer overflows come from this clock domain and need no synchroniser.
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         t1_half <= 1'b0;
         m2_div  <= 2'h0;
         tick    <= 1'b0;
         tx_cnt  <= 4'h0;
      end else begin
         tick <= next_tick;
         if (timer1_ovf_in)
            t1_half <= ~t1_half;
         if (next_tick)
            m2_div <= 2'h0;
         else
            m2_div <= m2_div + 2'h1;
         if (tick)
            tx_cnt <= tx_cnt + 4'h1;
      end
   end

   // ----------------------------------------------------------------------------
   // Transmitter
   // ----------------------------------------------------------------------------
   // A buffer write is applied last so it overrides any shift in the same cycle.
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tx_sr      <= 9'h0;
         tx_pend    <= 1'b0;
         tx_arm     <= 1'b0;
         send       <= 1'b0;
         tx_data_on <= 1'b0;
         tx_first   <= 1'b0;
         ti_set     <= 1'b0;
      end else begin
         ti_set <= 1'b0;
         if (mode0) begin
            if (mc_end & tx_pend & ~send) begin
               send    <= 1'b1;
               tx_pend <= 1'b0;
            end else if (mc_end & send) begin
               tx_sr <= {1'b0, tx_sr[8:1]};
               if (tx_last) begin
                  send   <= 1'b0;
                  ti_set <= 1'b1;
               end
            end
         end else begin
            if (tx_roll & tx_pend & ~send)
               tx_arm <= 1'b1;
            if (mc_end & tx_arm) begin
               send       <= 1'b1;
               tx_data_on <= 1'b0;
               tx_first   <= 1'b1;
               tx_arm     <= 1'b0;
               tx_pend    <= 1'b0;
            end else if (tx_roll & send) begin
               if (!tx_data_on) begin
                  tx_data_on <= 1'b1;
               end else begin
                  tx_sr    <= {tx_first & (mode != `MODE_8BIT), tx_sr[8:1]};
                  tx_first <= 1'b0;
                  if (tx_last) begin
                     send       <= 1'b0;
                     tx_data_on <= 1'b0;
                     ti_set     <= 1'b1;
                  end
               end
            end
         end
         if (wr_buf) begin
            tx_sr   <= {(mode == `MODE_SHIFT) | (mode == `MODE_8BIT) | tx_ninth_bit,
                        writedata_in[7:0]};
            tx_pend <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Receive pin synchroniser
   // ----------------------------------------------------------------------------
   // Edge detection looks only at the second and third stages.
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rxd_meta <= 1'b1;
         rxd_sync <= 1'b1;
         rxd_prev <= 1'b1;
      end else begin
         rxd_meta <= rxd_in;
         rxd_sync <= rxd_meta;
         rxd_prev <= rxd_sync;
      end
   end

   majority_sampler majority_sampler_inst (
      .mclk_in  (mclk_in),
      .rstn_in  (rstn_in),
      .tick_in  (tick),
      .count_in (rx_cnt),
      .bit_in   (rxd_sync),
      .vote_out (vote)
   );

   // ----------------------------------------------------------------------------
   // Receiver
   // ----------------------------------------------------------------------------
   // Mode 0 sequencer and the asynchronous frame receiver share the shift register.
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rx_sr         <= `RX_PRESET;
         rx_cnt        <= 4'h0;
         rx_busy       <= 1'b0;
         rx_first      <= 1'b0;
         rx_tail       <= 1'b0;
         rx0_state     <= RX0_IDLE;
         receive       <= 1'b0;
         rx0_sample    <= 1'b1;
         ri_set        <= 1'b0;
         serial_buffer <= 8'h0;
         rx_ninth_bit  <= 1'b0;
      end else begin
         ri_set <= 1'b0;
         if (mode0) begin
            rx_busy <= 1'b0;
            case (rx0_state)
               RX0_IDLE: begin
                  if (rx_enable & ~rx_done_flag & ~ri_set)
                     rx0_state <= RX0_WAIT;
               end
               RX0_WAIT: begin
                  if (mc_end)
                     rx0_state <= RX0_LOAD;
               end
               RX0_LOAD: begin
                  if (mc_end) begin
                     rx_sr[7:0] <= `RX0_PRESET;
                     rx0_state  <= RX0_RUN;
                  end
               end
               default: begin
                  if (!receive) begin
                     receive <= 1'b1;
                  end else begin
                     if (mc_cnt == `MC_SAMPLE)
                        rx0_sample <= rxd_sync;
                     if (mc_end) begin
                        rx_sr[7:0] <= {rx_sr[6:0], rx0_sample};
                        if (!rx_sr[7]) begin
                           serial_buffer <= {rx_sr[6:0], rx0_sample};
                           receive       <= 1'b0;
                           rx0_state     <= RX0_IDLE;
                           ri_set        <= 1'b1;
                        end
                     end
                  end
               end
            endcase
         end else begin
            receive   <= 1'b0;
            rx0_state <= RX0_IDLE;
            if (!rx_busy) begin
               if (rx_enable & fall) begin
                  rx_busy  <= 1'b1;
                  rx_cnt   <= 4'h0;
                  rx_sr    <= `RX_PRESET;
                  rx_first <= 1'b1;
                  rx_tail  <= 1'b0;
               end
            end else if (tick) begin
               rx_cnt <= rx_cnt + 4'h1;
               if (rx_roll) begin
                  if (rx_tail) begin
                     rx_busy <= 1'b0;
                  end else if (rx_first & vote) begin
                     rx_busy <= 1'b0;
                  end else begin
                     rx_first <= 1'b0;
                     rx_sr    <= {vote, rx_sr[8:1]};
                     if (!rx_sr[0]) begin
                        // Final shift: vote is the stop bit or the ninth data bit.
                        if (~rx_done_flag & ~ri_set & (~address_filter_bit | vote)) begin
                           serial_buffer <= rx_sr[8:1];
                           rx_ninth_bit  <= vote;
                           ri_set        <= 1'b1;
                        end
                        if (mode == `MODE_8BIT)
                           rx_busy <= 1'b0;
                        else
                           rx_tail <= 1'b1;
                     end
                  end
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------------------
   // Registered so the pins never glitch; the shift clock idles high.
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         txd_out    <= 1'b1;
         rxd_out    <= 1'b1;
         rxd_oe_out <= 1'b0;
      end else begin
         rxd_oe_out <= mode0 & send;
         rxd_out    <= (mode0 & send) ? tx_sr[0] : 1'b1;
         if (mode0)
            txd_out <= (send | receive) ? (mc_cnt < `MC_CLK_LOW) : 1'b1;
         else
            txd_out <= send ? (tx_data_on & tx_sr[0]) : 1'b1;
      end
   end

endmodule

// ### tb/serial_port_shift_engine_assertions.sv
// Pin-level checks of the serial shift engine: bus answers and the mode 0 shift clock.
`timescale 1ns/1ps
module serial_port_shift_engine_assertions (
   input wire logic        mclk_in,
   input wire logic        rstn_in,
   input wire logic [3:0]  address_in,
   input wire logic        read_in,
   input wire logic        write_in,
   input wire logic [31:0] writedata_in,
   input wire logic [3:0]  byteenable_in,
   input wire logic [31:0] readdata_out,
   input wire logic        waitrequest_out,
   input wire logic        timer1_ovf_in,
   input wire logic        timer2_ovf_in,
   input wire logic        rxd_in,
   input wire logic        rxd_out,
   input wire logic        rxd_oe_out,
   input wire logic        txd_out
);
default clocking @(posedge mclk_in); endclocking
default disable iff (!rstn_in);
logic [3:0] pulses;
logic       tprev;
// Counts shift clock falls while the data pin is driven, so a short or long send shows.
always @(posedge mclk_in or negedge rstn_in) begin
   if (!rstn_in) begin
      pulses <= 4'h0;
      tprev <= 1'b1;
   end else begin
      tprev <= txd_out;
      pulses <= !rxd_oe_out ? 4'h0 : pulses + {3'h0, tprev & ~txd_out};
   end
end
AST_WAIT_ANSWER: assert property ((read_in || write_in) && waitrequest_out |=> !waitrequest_out)
   else $error("bus access not answered in the next cycle");
AST_WAIT_ONE: assert property (!waitrequest_out |=> waitrequest_out)
   else $error("waitrequest low for more than one cycle");
AST_UPPER_ZERO: assert property (read_in && !waitrequest_out |-> readdata_out[31:8] == 24'h0)
   else $error("read data upper bits not zero");
AST_IDLE_DATA: assert property (!rxd_oe_out |-> rxd_out)
   else $error("data pin output not high while released");
AST_CLK_LOW: assert property ($fell(txd_out) && rxd_oe_out |-> !txd_out [*6] ##1 txd_out)
   else $error("shift clock low phase not six clocks");
AST_CLK_HIGH: assert property ($rose(txd_out) && rxd_oe_out |-> txd_out [*6])
   else $error("shift clock high phase shorter than six clocks");
AST_DATA_STEADY: assert property (rxd_oe_out && !txd_out && !$past(txd_out) |-> $stable(rxd_out))
   else $error("send data moved while shift clock low");
AST_EIGHT_CLOCKS: assert property ($fell(rxd_oe_out) |-> pulses == 4'h8)
   else $error("mode 0 send did not give eight shift clocks");
endmodule

// ### tb/serial_remote_model.sv
// Remote serial party: frame sender, frame decoder and mode 0 external shift register.
`timescale 1ns/1ps
module serial_remote_model (
   input  wire logic       mclk_in,
   input  wire logic       txd_in,
   input  wire logic       dat_in,
   input  wire logic       oe_in,
   output logic            line_out = 1'b1,
   output logic            done_out = 1'b0,
   output logic [9:0]      frame_out = 10'h0
);
int         bitclk = 0;
int         nbits = 9;
int         cnt = 0;
int         k = 0;
logic       busy = 1'b0;
logic       tprev = 1'b1;
logic       m0 = 1'b0;
logic [9:0] sh = 10'h0;
// Decodes what the engine sends; a zero bit clock mutes the frame decoder in mode 0.
always @(posedge mclk_in) begin
   done_out <= 1'b0;
   tprev <= txd_in;
   if (oe_in) begin
      m0 <= 1'b1;
      if (tprev && !txd_in) sh <= {dat_in, sh[9:1]};
   end else if (m0) begin
      m0 <= 1'b0;
      frame_out <= {2'h0, sh[9:2]};
      done_out <= 1'b1;
   end else if (busy) begin
      cnt <= cnt + 1;
      // Mid-bit sampling keeps a clock or two of skew harmless.
      if (cnt == bitclk * k + bitclk / 2) begin
         k <= k + 1;
         if (k > 0) sh <= {txd_in, sh[9:1]};
         if (k == nbits) begin
            busy <= 1'b0;
            frame_out <= {txd_in, sh[9:1]} >> (10 - nbits);
            done_out <= 1'b1;
         end
      end
   end else if (bitclk != 0 && tprev && !txd_in) begin
      busy <= 1'b1;
      cnt <= 1;
      k <= 0;
   end
end
// Sends a start bit, then n bits LSB first; the line idles high afterwards.
task send(input logic [9:0] fr, input int n, input int bc);
   line_out <= 1'b0;
   repeat (bc) @(posedge mclk_in);
   for (int i = 0; i < n; i++) begin
      line_out <= fr[i];
      repeat (bc) @(posedge mclk_in);
   end
   line_out <= 1'b1;
endtask
// Presents one bit per shift clock, changing only after the clock has risen.
task feed(input logic [7:0] v);
   logic p;
   for (int i = 7; i >= 0; i--) begin
      line_out <= v[i];
      p = txd_in;
      @(posedge mclk_in);
      while (!(txd_in && !p)) begin
         p = txd_in;
         @(posedge mclk_in);
      end
   end
   line_out <= 1'b1;
endtask
endmodule

// ### tb/serial_port_shift_engine_tb_top.sv
// Self-checking bench of the serial shift engine against a remote serial party.
`timescale 1ns/1ps
`include "serial_engine_defs.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("Error at %0t: got %0h expected %0h", $time, a, e); end end
module serial_port_shift_engine_tb_top;
logic        mclk_in = 1'b0, rstn_in = 1'b0, read_in = 1'b0, write_in = 1'b0, chk = 1'b0;
logic [3:0]  address_in = 4'h0, byteenable_in = 4'h0;
logic [31:0] writedata_in = 32'h0, readdata_out, q, ev;
logic        waitrequest_out, rxd_out, rxd_oe_out, txd_out, line, fdone, n9, r9;
logic        timer1_ovf_in = 1'b0, timer2_ovf_in = 1'b0, last9 = 1'b0;
logic [9:0]  frame, fv;
logic [7:0]  b, b2, cv;
logic [15:0] cyc = 16'h0;
int          mismatches = 0, n_checks = 0;
int          md[5] = '{1, 1, 3, 2, 2}, cf[5] = '{2, 1, 0, 0, 1}, bc[5] = '{32, 32, 64, 64, 32};
logic [31:0] exp_q[$];
logic [9:0]  fq[$];
// The data pin is shared: the engine drives it in mode 0 send, the remote party otherwise.
wire         rxd_pin = rxd_oe_out ? rxd_out : line;
serial_port_shift_engine serial_port_shift_engine_inst (.mclk_in, .rstn_in, .address_in,
   .read_in, .write_in, .writedata_in, .byteenable_in, .readdata_out, .waitrequest_out,
   .timer1_ovf_in, .timer2_ovf_in, .rxd_in(rxd_pin), .rxd_out, .rxd_oe_out, .txd_out);
serial_remote_model serial_remote_model_inst (.mclk_in, .txd_in(txd_out), .dat_in(rxd_pin),
   .oe_in(rxd_oe_out), .line_out(line), .done_out(fdone), .frame_out(frame));
always #20 mclk_in = ~mclk_in;
// Overflow pulses every second clock; the cycle ceiling cuts a hung wait short.
always @(posedge mclk_in) begin
   cyc <= cyc + 16'h1;
   timer1_ovf_in <= cyc[0];
   timer2_ovf_in <= ~cyc[0];
   if (cyc == 16'h9c40) begin
      mismatches++;
      give_verdict;
   end
end
// Results are compared with the oldest note as they appear at the pins.
always @(posedge mclk_in) begin
   if (read_in && waitrequest_out === 1'b0 && chk) begin
      ev = exp_q.pop_front();
      `CHK(readdata_out, ev)
   end
   if (fdone === 1'b1) begin
      fv = fq.pop_front();
      `CHK(frame, fv)
   end
end
task wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] be = 4'h1);
   @(posedge mclk_in);
   address_in <= a;
   write_in <= 1'b1;
   writedata_in <= {24'h0, d};
   byteenable_in <= be;
   do @(posedge mclk_in); while (waitrequest_out !== 1'b0);
   write_in <= 1'b0;
endtask
task rd(input logic [3:0] a, input logic [7:0] e, input logic c);
   @(posedge mclk_in);
   address_in <= a;
   read_in <= 1'b1;
   chk <= c;
   if (c) exp_q.push_back({24'h0, e});
   do @(posedge mclk_in); while (waitrequest_out !== 1'b0);
   q = readdata_out;
   read_in <= 1'b0;
endtask
task ck(input logic [3:0] a, input logic [7:0] e);
   rd(a, e, 1'b1);
endtask
task poll(input int i);
   do rd(`REG_CTRL, 8'h0, 1'b0); while (q[i] !== 1'b1);
endtask
task tdone(input string s);
   $display("test %s done", s);
endtask
task give_verdict;
   $display("checks %0d mismatches %0d", n_checks, mismatches);
   if (mismatches == 0 && n_checks > 0) $display("bench passed");
   else $display("bench failed");
   $finish;
endtask
// Main sequence: registers, five runs over frame modes 1 to 3, then mode 0 both ways.
initial begin
   void'($urandom(32'h7227f2e8));
   repeat (12) @(posedge mclk_in);
   rstn_in <= 1'b1;
   foreach (md[i]) ck(4'(4 * i), 8'h0);
   ck(4'h2, 8'h0);
   wr(`REG_CFG, 8'h03, 4'he);
   wr(`REG_STAT, 8'hff);
   ck(`REG_CFG, 8'h0);
   ck(`REG_STAT, 8'h0);
   tdone("registers");
   for (int i = 0; i < 5; i++) begin
      b = 8'($urandom);
      b2 = 8'($urandom);
      n9 = 1'($urandom);
      r9 = (md[i] == 1) ? 1'b1 : 1'($urandom);
      cv = 8'(md[i] << 6) | 8'h10 | {4'h0, n9, 3'h0};
      serial_remote_model_inst.bitclk = bc[i];
      serial_remote_model_inst.nbits = (md[i] == 1) ? 9 : 10;
      wr(`REG_CFG, 8'(cf[i]));
      wr(`REG_CTRL, cv);
      fq.push_back((md[i] == 1) ? {2'b01, b} : {1'b1, n9, b});
      wr(`REG_BUF, b);
      poll(`CTRL_TX_DONE);
      ck(`REG_CTRL, cv | {5'h0, last9, 2'b10});
      serial_remote_model_inst.send(10'h0, 0, 4);
      // Let the rejected glitch end and the receiver go back to hunting first.
      repeat (2 * bc[i]) @(posedge mclk_in);
      serial_remote_model_inst.send({1'b1, r9, b2}, serial_remote_model_inst.nbits, bc[i]);
      poll(`CTRL_RX_DONE);
      ck(`REG_BUF, b2);
      ck(`REG_CTRL, cv | {5'h0, r9, 2'b11});
      repeat (2 * bc[i]) @(posedge mclk_in);
      serial_remote_model_inst.send({2'b11, ~b2}, serial_remote_model_inst.nbits, bc[i]);
      repeat (2 * bc[i]) @(posedge mclk_in);
      wr(`REG_CTRL, cv | 8'h20);
      serial_remote_model_inst.send({2'b10, ~b2}, serial_remote_model_inst.nbits, bc[i]);
      repeat (2 * bc[i]) @(posedge mclk_in);
      ck(`REG_BUF, b2);
      ck(`REG_CTRL, cv | 8'h20 | {5'h0, r9, 2'b00});
      last9 = r9;
      tdone("frame mode");
   end
   serial_remote_model_inst.bitclk = 0;
   b = 8'($urandom);
   wr(`REG_CTRL, 8'h00);
   fq.push_back({2'b00, b});
   wr(`REG_BUF, b);
   poll(`CTRL_TX_DONE);
   ck(`REG_CTRL, {5'h0, last9, 2'b10});
   fork
      serial_remote_model_inst.feed(b2);
   join_none
   wr(`REG_CTRL, 8'h10);
   poll(`CTRL_RX_DONE);
   ck(`REG_BUF, b2);
   wr(`REG_CTRL, 8'h00);
   tdone("mode 0");
   give_verdict;
end
endmodule
bind serial_port_shift_engine serial_port_shift_engine_assertions
   serial_port_shift_engine_assertions_inst (.mclk_in, .rstn_in, .address_in, .read_in,
   .write_in, .writedata_in, .byteenable_in, .readdata_out, .waitrequest_out,
   .timer1_ovf_in, .timer2_ovf_in, .rxd_in, .rxd_out, .rxd_oe_out, .txd_out);
